//--- hdl/tmra_pkg.sv
// Purpose: types shared by the temperature monitor design
// Assumes: nothing beyond SystemVerilog packages
// Notes: constants live in tmra_regs.svh
`default_nettype none
package tmra_pkg;
  // monitor sequencer states
  typedef enum logic [1:0] {ST_PICK, ST_START, ST_WAIT} tmra_state_t;
endpackage : tmra_pkg
`default_nettype wire

//--- hdl/tmra_regs.svh
// Purpose: register offsets, field positions, reset values and timing figures of the temperature monitor
// Assumes: 32-bit register port, byte offsets on word boundaries
// Notes: definitions only
`ifndef TMRA_REGS_SVH
`define TMRA_REGS_SVH
// register byte offsets
`define TMRA_A_CFG 8'h00
`define TMRA_A_IDEAL 8'h04
`define TMRA_A_GAIN 8'h08
`define TMRA_A_TLIM 8'h0c
`define TMRA_A_ALIM 8'h10
`define TMRA_A_STAT 8'h14
`define TMRA_A_MASK 8'h18
`define TMRA_A_TLOC 8'h1c
`define TMRA_A_TR1 8'h20
`define TMRA_A_TR2 8'h24
`define TMRA_A_MON 8'h28
// sensor configuration fields
`define TMRA_CFG_LT 0
`define TMRA_CFG_R1 1
`define TMRA_CFG_R2 2
`define TMRA_CFG_RC 3
`define TMRA_CFG_RST 4'hf
// gain register: range gain bits [3:0], differential pair bits [5:4]
`define TMRA_GAIN_DIFF_LSB 4
`define TMRA_GAIN_RST 6'h00
// limit registers: high limit [27:16], low limit [11:0]
`define TMRA_LIM_HI_LSB 16
`define TMRA_TLIM_HI_RST 12'h7ff
`define TMRA_TLIM_LO_RST 12'h800
`define TMRA_ALIM_HI_RST 12'hfff
`define TMRA_ALIM_LO_RST 12'h000
// ideality correction: effective ideality = 1.008 * 300 / (300 - n)
`define TMRA_IDEAL_RST 8'h00
`define TMRA_IDEAL_BASE 10'h12c
// alarm sources: [3:0] analog channels 0..3, [6:4] local, remote one, remote two
`define TMRA_NSRC 7
`define TMRA_NTEMP 3
`define TMRA_TEMP_LSB 4
`define TMRA_FILT_CNT 4
// slot times in ms and clock in kHz
`define TMRA_T_LOCAL_MS 15
`define TMRA_T_REMOTE_MS 44
`define TMRA_T_REMOTE_RC_MS 93
`define TMRA_CLK_KHZ 100000
`define TMRA_LAST_SENSOR 2'h2
`endif

//--- hdl/tmra_top.sv
// Purpose: background temperature monitor sequencer, result registers and range alarm logic
// Assumes: secondary converter, primary ADC and serial shift logic all run on MCLK_I
// Notes: register port has read data one cycle after the read strobe
//
// Behaviour
// - out-of-range input sets its own status flag
// - alarm pin low while any input out
// - consecutive-sample filter blocks transient alarms
// - range gain bit selects one or two spans
// - differential pairs use bipolar range
// - disabled sensors are skipped, never converted
// - monitor cycle restarts itself forever
// - secondary converter runs beside primary ADC
// - each sensor has own result register
// - results are 12-bit two's complement
// - ideality correction signed, divisor 300 minus value
// - ideality correction resets to zero
// - resistance cancellation only while bit set
// - result update waits for host transfer
// - cycle length follows enables and cancellation
`include "tmra_regs.svh"
`default_nettype none
module tmra_top #(
  parameter int T_LOCAL_CYC = `TMRA_T_LOCAL_MS * `TMRA_CLK_KHZ,        // local sensor slot
  parameter int T_REMOTE_CYC = `TMRA_T_REMOTE_MS * `TMRA_CLK_KHZ,      // remote slot, no cancel
  parameter int T_REMOTE_RC_CYC = `TMRA_T_REMOTE_RC_MS * `TMRA_CLK_KHZ, // remote slot, cancel on
  parameter int FILT_N = `TMRA_FILT_CNT                                 // samples to confirm
) (
  input wire logic MCLK_I,
  input wire logic RST_B_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  output logic IRQ_O,
  output logic ALARM_B_O,
  output logic TS_START_O,
  output logic [1:0] TS_SEL_O,
  output logic TS_RC_O,
  output logic [9:0] TS_IDEAL_DEN_O,
  input wire logic TS_DONE_I,
  input wire logic [11:0] TS_DATA_I,
  input wire logic ADC_VLD_I,
  input wire logic [3:0] ADC_CH_I,
  input wire logic [11:0] ADC_DATA_I,
  output logic [3:0] ADC_GAIN_O,
  output logic [3:0] ADC_BIPOLAR_O,
  input wire logic XFER_BUSY_I
);

  // range check, signed or unsigned compare against high and low limits
  function automatic logic out_of_range(input logic [11:0] d, input logic [11:0] hi,
                                        input logic [11:0] lo, input logic sgn);
    if (sgn) begin
      out_of_range = ($signed(d) > $signed(hi)) || ($signed(d) < $signed(lo));
    end else begin
      out_of_range = (d > hi) || (d < lo);
    end
  endfunction : out_of_range

  // software registers
  logic [3:0] cfg_q;            // sensor enables and cancel bit
  logic [7:0] ideal_q;          // signed ideality correction
  logic [5:0] gain_q;           // range gains and differential pairs
  logic [23:0] tlim_q;          // temperature limits {hi, lo}
  logic [23:0] alim_q;          // analog limits {hi, lo}
  logic [`TMRA_NSRC-1:0] stat_q; // sticky alarm flags
  logic [`TMRA_NSRC-1:0] mask_q; // interrupt mask
  logic [31:0] rdata_q;
  logic irq_q;
  logic alarm_b_q;
  // sequencer state
  tmra_pkg::tmra_state_t st_q;
  logic [1:0] cur_q;            // sensor in this slot
  logic [31:0] tmr_q;           // least slot time left
  logic done_q;                 // converter answered in this slot
  logic [15:0] cyc_cnt_q;       // completed monitor cycles
  logic ts_start_q;
  logic [1:0] ts_sel_q;
  logic ts_rc_q;
  logic [9:0] den_q;
  // results
  logic [11:0] tdat_q [`TMRA_NTEMP];
  logic [11:0] pend_dat_q [`TMRA_NTEMP];
  logic [`TMRA_NTEMP-1:0] pend_vld_q;
  // alarm filter
  logic [3:0] flt_cnt_q [`TMRA_NSRC];
  logic [`TMRA_NSRC-1:0] oor_act;   // confirmed out of range
  logic [`TMRA_NSRC-1:0] oor_raw;   // current sample out of range
  logic [`TMRA_NSRC-1:0] smp_vld;   // new sample for that source

  // write decode
  wire wr_cfg = WR_I && (ADDR_I == `TMRA_A_CFG);
  wire wr_ideal = WR_I && (ADDR_I == `TMRA_A_IDEAL);
  wire wr_gain = WR_I && (ADDR_I == `TMRA_A_GAIN);
  wire wr_tlim = WR_I && (ADDR_I == `TMRA_A_TLIM);
  wire wr_alim = WR_I && (ADDR_I == `TMRA_A_ALIM);
  wire wr_stat = WR_I && (ADDR_I == `TMRA_A_STAT);
  wire wr_mask = WR_I && (ADDR_I == `TMRA_A_MASK);
  // sequencer helpers
  wire en_cur = cfg_q[cur_q];
  wire is_remote = (cur_q != 2'h0);
  wire [1:0] cur_nxt = (cur_q == `TMRA_LAST_SENSOR) ? 2'h0 : cur_q + 2'h1;
  wire cyc_end = (cur_q == `TMRA_LAST_SENSOR);
  wire wait_done = (done_q || TS_DONE_I) && (tmr_q == 32'h0);
  wire ts_done_ok = TS_DONE_I && (st_q == tmra_pkg::ST_WAIT) && !done_q;
  // slot length per sensor and cancel setting
  wire [31:0] slot_len = !is_remote ? 32'(T_LOCAL_CYC) :
                         cfg_q[`TMRA_CFG_RC] ? 32'(T_REMOTE_RC_CYC) : 32'(T_REMOTE_CYC);
  wire [`TMRA_NSRC-1:0] stat_d = (stat_q & ~(wr_stat ? WDATA_I[`TMRA_NSRC-1:0] : '0)) | oor_act;
  wire [9:0] den_d = 10'(`TMRA_IDEAL_BASE - {{2{ideal_q[7]}}, ideal_q});

  // read mux
  logic [31:0] rd_mux;
  always_comb begin
    if (ADDR_I == `TMRA_A_CFG) begin
      rd_mux = {28'h0, cfg_q};
    end else if (ADDR_I == `TMRA_A_IDEAL) begin
      rd_mux = {24'h0, ideal_q};
    end else if (ADDR_I == `TMRA_A_GAIN) begin
      rd_mux = {26'h0, gain_q};
    end else if (ADDR_I == `TMRA_A_TLIM) begin
      rd_mux = {4'h0, tlim_q[23:12], 4'h0, tlim_q[11:0]};
    end else if (ADDR_I == `TMRA_A_ALIM) begin
      rd_mux = {4'h0, alim_q[23:12], 4'h0, alim_q[11:0]};
    end else if (ADDR_I == `TMRA_A_STAT) begin
      rd_mux = {25'h0, stat_q};
    end else if (ADDR_I == `TMRA_A_MASK) begin
      rd_mux = {25'h0, mask_q};
    end else if (ADDR_I == `TMRA_A_TLOC) begin
      rd_mux = {20'h0, tdat_q[0]};
    end else if (ADDR_I == `TMRA_A_TR1) begin
      rd_mux = {20'h0, tdat_q[1]};
    end else if (ADDR_I == `TMRA_A_TR2) begin
      rd_mux = {20'h0, tdat_q[2]};
    end else if (ADDR_I == `TMRA_A_MON) begin
      rd_mux = {cyc_cnt_q, 9'h0, pend_vld_q, cur_q, st_q};
    end else begin
      rd_mux = 32'h0; // unmapped reads return zero
    end
  end

  // register file, status and pins
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      cfg_q <= `TMRA_CFG_RST;
      ideal_q <= `TMRA_IDEAL_RST;
      gain_q <= `TMRA_GAIN_RST;
      tlim_q <= {`TMRA_TLIM_HI_RST, `TMRA_TLIM_LO_RST};
      alim_q <= {`TMRA_ALIM_HI_RST, `TMRA_ALIM_LO_RST};
      stat_q <= '0;
      mask_q <= '0;
      rdata_q <= 32'h0;
      irq_q <= 1'b0;
      alarm_b_q <= 1'b1;
      den_q <= `TMRA_IDEAL_BASE;
    end else begin
      if (wr_cfg) cfg_q <= WDATA_I[3:0];
      if (wr_ideal) ideal_q <= WDATA_I[7:0];
      if (wr_gain) gain_q <= WDATA_I[5:0];
      if (wr_tlim) tlim_q <= {WDATA_I[`TMRA_LIM_HI_LSB +: 12], WDATA_I[11:0]};
      if (wr_alim) alim_q <= {WDATA_I[`TMRA_LIM_HI_LSB +: 12], WDATA_I[11:0]};
      if (wr_mask) mask_q <= WDATA_I[`TMRA_NSRC-1:0];
      stat_q <= stat_d;                               // set wins over clear
      rdata_q <= RD_I ? rd_mux : 32'h0;
      irq_q <= |(stat_q & mask_q);
      alarm_b_q <= !((|stat_q) || (|oor_act));
      den_q <= den_d;
    end
  end

  // gain and pair mode towards the primary converter
  logic [3:0] gain_out_q;
  logic [3:0] bip_out_q;
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      gain_out_q <= 4'h0;
      bip_out_q <= 4'h0;
    end else begin
      gain_out_q <= gain_q[3:0];
      bip_out_q <= {{2{gain_q[`TMRA_GAIN_DIFF_LSB+1]}}, {2{gain_q[`TMRA_GAIN_DIFF_LSB]}}};
    end
  end

  // monitor sequencer, independent of the primary ADC path
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      st_q <= tmra_pkg::ST_PICK;
      cur_q <= 2'h0;
      tmr_q <= 32'h0;
      done_q <= 1'b0;
      cyc_cnt_q <= 16'h0;
      ts_start_q <= 1'b0;
      ts_sel_q <= 2'h0;
      ts_rc_q <= 1'b0;
    end else begin
      ts_start_q <= 1'b0;
      case (st_q)
        tmra_pkg::ST_PICK: begin
          if (en_cur) begin
            st_q <= tmra_pkg::ST_START;
            ts_start_q <= 1'b1;
            ts_sel_q <= cur_q;
            ts_rc_q <= is_remote && cfg_q[`TMRA_CFG_RC];
          end else begin
            cur_q <= cur_nxt;                               // skip disabled sensor
            if (cyc_end) cyc_cnt_q <= cyc_cnt_q + 16'h1;
          end
        end
        tmra_pkg::ST_START: begin
          tmr_q <= slot_len;
          done_q <= 1'b0;
          st_q <= tmra_pkg::ST_WAIT;
        end
        tmra_pkg::ST_WAIT: begin
          if (tmr_q != 32'h0) tmr_q <= tmr_q - 32'h1;
          if (TS_DONE_I) done_q <= 1'b1;
          if (wait_done) begin
            st_q <= tmra_pkg::ST_PICK;
            cur_q <= cur_nxt;
            if (cyc_end) cyc_cnt_q <= cyc_cnt_q + 16'h1;    // new cycle, no host action
          end
        end
        default: st_q <= tmra_pkg::ST_PICK;
      endcase
    end
  end

  // per-sensor result registers with hold while the host transfers
  for (genvar s = 0; s < `TMRA_NTEMP; s++) begin : g_res
    always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
        tdat_q[s] <= 12'h000;
        pend_dat_q[s] <= 12'h000;
        pend_vld_q[s] <= 1'b0;
      end else begin
        if (pend_vld_q[s] && !XFER_BUSY_I) begin
          tdat_q[s] <= pend_dat_q[s];   // 12-bit two's complement, 0.125 degree lsb
          pend_vld_q[s] <= 1'b0;
        end
        if (ts_done_ok && (cur_q == 2'(s))) begin
          pend_dat_q[s] <= TS_DATA_I;
          pend_vld_q[s] <= 1'b1;        // new result wins over the transfer
        end
      end
    end
  end

  // sample strobes and raw range checks for analog channels and sensors
  for (genvar i = 0; i < `TMRA_NSRC; i++) begin : g_src
    if (i < `TMRA_TEMP_LSB) begin : g_ana
      assign smp_vld[i] = ADC_VLD_I && (ADC_CH_I == 4'(i));
      assign oor_raw[i] = out_of_range(ADC_DATA_I, alim_q[23:12], alim_q[11:0],
                                       gain_q[`TMRA_GAIN_DIFF_LSB + i/2]);
    end else begin : g_tmp
      assign smp_vld[i] = ts_done_ok && (cur_q == 2'(i - `TMRA_TEMP_LSB));
      assign oor_raw[i] = out_of_range(TS_DATA_I, tlim_q[23:12], tlim_q[11:0], 1'b1);
    end
    // consecutive out-of-range samples needed before an alarm
    always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
        flt_cnt_q[i] <= 4'h0;
      end else if (smp_vld[i]) begin
        if (!oor_raw[i]) flt_cnt_q[i] <= 4'h0;
        else if (flt_cnt_q[i] != 4'(FILT_N)) flt_cnt_q[i] <= flt_cnt_q[i] + 4'h1;
      end
    end
    assign oor_act[i] = (flt_cnt_q[i] == 4'(FILT_N));
  end

  assign RDATA_O = rdata_q;
  assign IRQ_O = irq_q;
  assign ALARM_B_O = alarm_b_q;
  assign TS_START_O = ts_start_q;
  assign TS_SEL_O = ts_sel_q;
  assign TS_RC_O = ts_rc_q;
  assign TS_IDEAL_DEN_O = den_q;
  assign ADC_GAIN_O = gain_out_q;
  assign ADC_BIPOLAR_O = bip_out_q;

  // checks
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_B_I);

  chk_flag_set: assert property (##1 (($past(oor_act) & ~stat_q) == '0))
    else $error("confirmed out-of-range input left its flag clear");
  chk_alarm_low: assert property ((|stat_q) |=> !ALARM_B_O)
    else $error("alarm pin high while a flag is set");
  chk_alarm_release: assert property ((stat_q == '0 && oor_act == '0) |=> ALARM_B_O)
    else $error("alarm pin low with nothing out of range");
  chk_filter_single: assert property ((smp_vld[0] && oor_raw[0] && flt_cnt_q[0] == 4'h0) |=> !oor_act[0])
    else $error("single excursion raised an alarm");
  chk_skip_disabled: assert property ((st_q == tmra_pkg::ST_PICK && !en_cur) |=> !TS_START_O)
    else $error("conversion started for a disabled sensor");
  chk_cycle_restart: assert property ((st_q == tmra_pkg::ST_WAIT && wait_done && cyc_end)
    |=> (cur_q == 2'h0 && st_q == tmra_pkg::ST_PICK && cyc_cnt_q == $past(cyc_cnt_q) + 16'h1))
    else $error("monitor cycle did not restart");
  chk_data_freeze: assert property (XFER_BUSY_I |=> $stable({tdat_q[0], tdat_q[1], tdat_q[2]}))
    else $error("result register changed during host transfer");
  chk_result_store: assert property ((pend_vld_q[1] && !XFER_BUSY_I) |=> tdat_q[1] == $past(pend_dat_q[1]))
    else $error("pending result not moved into its register");
  chk_ideal_div: assert property (wr_ideal |=> ##1
    (TS_IDEAL_DEN_O == 10'(`TMRA_IDEAL_BASE - {{2{$past(WDATA_I[7], 2)}}, $past(WDATA_I[7:0], 2)})))
    else $error("ideality divisor wrong after write");
  chk_rc_gate: assert property (TS_START_O |-> (TS_RC_O == ((TS_SEL_O != 2'h0) && $past(cfg_q[`TMRA_CFG_RC]))))
    else $error("cancellation request does not follow the cancel bit");
  chk_slot_len: assert property ((st_q == tmra_pkg::ST_START) |=> (tmr_q == $past(slot_len)))
    else $error("slot timer loaded with wrong length");
  chk_gain_out: assert property (wr_gain |=> ##1 (ADC_GAIN_O == $past(WDATA_I[3:0], 2)))
    else $error("range gain output does not follow register");

  cov_cycle_wrap: cover property (st_q == tmra_pkg::ST_WAIT && wait_done && cyc_end);
  cov_alarm_raise: cover property ($fell(ALARM_B_O));
  cov_frozen_result: cover property (pend_vld_q[0] && XFER_BUSY_I ##1 !XFER_BUSY_I);

endmodule : tmra_top
`default_nettype wire

//--- tb/tb.sv
// Purpose: self-checking bench for the temperature monitor, alarm and range gain block
// Assumes: short slot parameters, so one monitor cycle spans well under two hundred clocks
// Notes: the bench stands in for the host, the secondary converter and the primary adc
`include "tmra_regs.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 20000; // timeout ceiling in clocks
  typedef struct packed {logic [7:0] a; logic [31:0] rst; logic [31:0] w; logic [31:0] back;} tmra_row_t;
  logic mclk, rst_b, wr, rd, ts_done, adc_vld, busy; // host, converter and adc strobes
  logic [7:0] addr; // register byte address
  logic [31:0] wdata, rdata; // register data
  logic [11:0] ts_data, adc_data; // converter and adc results
  logic [3:0] adc_ch, gain, bipolar; // adc channel and range outputs
  logic irq, alarm_b, ts_start, ts_rc; // single-bit outputs
  logic [1:0] ts_sel; // sensor of the current request
  logic [9:0] den; // ideality divisor
  logic [11:0] temp [4]; // reading the converter returns per sensor
  int n_mismatch, checks, cyc, cnt, n_rc; // counters
  int n_sel [4]; // starts seen per sensor
  // ordinary cases: address, reset value, written value, read-back value
  tmra_row_t rows [7] = '{'{`TMRA_A_CFG, 32'h0000000f, 32'h0000000f, 32'h0000000f},
    '{`TMRA_A_TLIM, 32'h07ff0800, 32'h03e8fc00, 32'h03e80c00},
    '{`TMRA_A_ALIM, 32'h0fff0000, 32'hfc00f100, 32'h0c000100},
    '{`TMRA_A_MASK, 32'h00000000, 32'h0000007f, 32'h0000007f},
    '{`TMRA_A_STAT, 32'h00000000, 32'h0000007f, 32'h00000000},
    '{8'h2c, 32'h00000000, 32'hffffffff, 32'h00000000},
    '{`TMRA_A_IDEAL, 32'h00000000, 32'h1234567f, 32'h0000007f}};

  tmra_top #(.T_LOCAL_CYC(20), .T_REMOTE_CYC(40), .T_REMOTE_RC_CYC(60), .FILT_N(4)) tmra_top_inst (
    .MCLK_I(mclk), .RST_B_I(rst_b), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .IRQ_O(irq), .ALARM_B_O(alarm_b), .TS_START_O(ts_start), .TS_SEL_O(ts_sel), .TS_RC_O(ts_rc),
    .TS_IDEAL_DEN_O(den), .TS_DONE_I(ts_done), .TS_DATA_I(ts_data), .ADC_VLD_I(adc_vld), .ADC_CH_I(adc_ch),
    .ADC_DATA_I(adc_data), .ADC_GAIN_O(gain), .ADC_BIPOLAR_O(bipolar), .XFER_BUSY_I(busy));

  // clock at 100 mhz
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // converter stand-in: answers each start four clocks later, scrambles data while idle
  always @(posedge mclk) begin
    ts_done <= !ts_start && (cnt == 1);
    ts_data <= (!ts_start && (cnt == 1)) ? temp[ts_sel] : ~ts_data;
    if (ts_start) begin
      cnt <= 3;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end

  // start logger and hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (ts_start) begin
      n_sel[ts_sel]++;
      if (ts_rc) n_rc++;
    end
    if (cyc == LIMIT) begin
      n_mismatch++;
      results();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one-cycle register write
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wrr

  // one-cycle read, data taken in the following cycle
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rdc

  // n adc samples on one channel, data scrambled between strobes
  task automatic adc(input logic [3:0] ch, input logic [11:0] d, input int n);
    repeat (n) begin
      @(posedge mclk);
      adc_vld <= 1'b1;
      adc_ch <= ch;
      adc_data <= d;
      @(posedge mclk);
      adc_vld <= 1'b0;
      adc_data <= ~d;
    end
  endtask : adc

  // clear start counters away from the clock edge
  task automatic clr();
    @(posedge mclk);
    #1;
    foreach (n_sel[i]) n_sel[i] = 0;
    n_rc = 0;
  endtask : clr

  task automatic results();
    if (n_mismatch == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  // main sequence
  initial begin
    rst_b = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    ts_done = 1'b0;
    ts_data = 12'h000;
    adc_vld = 1'b0;
    adc_ch = 4'h0;
    adc_data = 12'h000;
    busy = 1'b0;
    {n_mismatch, checks, cyc, cnt, n_rc} = '0;
    foreach (n_sel[i]) n_sel[i] = 0;
    temp = '{12'h0c8, 12'hf38, 12'h190, 12'h000};
    repeat (11) @(posedge mclk);
    #1;
    chk(32'({alarm_b, irq, ts_start, ts_rc, den, gain, bipolar}), 32'({4'h8, 10'h12c, 8'h00}));
    @(posedge mclk) rst_b <= 1'b1;
    foreach (rows[i]) begin
      rdc(rows[i].a, rows[i].rst);
      wrr(rows[i].a, rows[i].w);
      rdc(rows[i].a, rows[i].back);
    end
    chk(32'(den), 32'h0ad);
    wrr(`TMRA_A_IDEAL, 32'h80);
    repeat (2) @(posedge mclk);
    #1;
    chk(32'(den), 32'h1ac);
    wrr(`TMRA_A_GAIN, 32'h3f);
    repeat (2) @(posedge mclk);
    #1;
    chk(32'({gain, bipolar}), 32'hff);
    wrr(`TMRA_A_GAIN, 32'h15);
    repeat (2) @(posedge mclk);
    #1;
    chk(32'({gain, bipolar}), 32'h53);
    wrr(`TMRA_A_GAIN, 32'h00);
    repeat (200) @(posedge mclk);
    rdc(`TMRA_A_TLOC, 32'h0c8);
    rdc(`TMRA_A_TR1, 32'hf38);
    rdc(`TMRA_A_TR2, 32'h190);
    // host transfer in progress holds the result register
    @(posedge mclk);
    busy <= 1'b1;
    temp[0] <= 12'h0c9;
    repeat (200) @(posedge mclk);
    rdc(`TMRA_A_TLOC, 32'h0c8);
    @(posedge mclk) busy <= 1'b0;
    repeat (3) @(posedge mclk);
    rdc(`TMRA_A_TLOC, 32'h0c9);
    // sensor enables, restart and cancellation
    wrr(`TMRA_A_CFG, 32'h5);
    clr();
    repeat (300) @(posedge mclk);
    chk(32'(n_sel[1]), 32'h0);
    chk(32'(n_sel[0] >= 2 && n_sel[2] >= 2), 32'h1);
    chk(32'(n_rc), 32'h0);
    wrr(`TMRA_A_CFG, 32'ha);
    clr();
    repeat (300) @(posedge mclk);
    chk(32'(n_sel[0] + n_sel[2]), 32'h0);
    chk(32'(n_sel[1] >= 3 && n_sel[1] <= 5), 32'h1);
    chk(32'(n_rc), 32'(n_sel[1]));
    // analog alarm: transient first, then a confirmed excursion
    adc(4'h0, 12'hd00, 3);
    adc(4'h0, 12'h800, 1);
    repeat (3) @(posedge mclk);
    rdc(`TMRA_A_STAT, 32'h0);
    chk(32'(alarm_b), 32'h1);
    adc(4'h2, 12'hd00, 4);
    repeat (3) @(posedge mclk);
    #1;
    chk(32'({alarm_b, irq}), 32'h1);
    rdc(`TMRA_A_STAT, 32'h04);
    adc(4'h2, 12'h800, 1);
    wrr(`TMRA_A_STAT, 32'h04);
    repeat (3) @(posedge mclk);
    #1;
    chk(32'({alarm_b, irq}), 32'h2);
    // pair two differential: signed compare puts 7ff above the negative high limit
    wrr(`TMRA_A_GAIN, 32'h20);
    adc(4'h2, 12'h7ff, 4);
    repeat (3) @(posedge mclk);
    rdc(`TMRA_A_STAT, 32'h04);
    wrr(`TMRA_A_GAIN, 32'h00);
    adc(4'h2, 12'h7ff, 1);
    wrr(`TMRA_A_STAT, 32'h04);
    // temperature alarm on remote two alone
    wrr(`TMRA_A_CFG, 32'h4);
    @(posedge mclk) temp[2] <= 12'h7d0;
    repeat (300) @(posedge mclk);
    rdc(`TMRA_A_STAT, 32'h40);
    chk(32'(alarm_b), 32'h0);
    @(posedge mclk) temp[2] <= 12'h190;
    repeat (100) @(posedge mclk);
    wrr(`TMRA_A_STAT, 32'h40);
    repeat (2) @(posedge mclk);
    #1;
    chk(32'(alarm_b), 32'h1);
    rdc(`TMRA_A_STAT, 32'h0);
    results();
  end
endmodule : tb
`default_nettype wire
